// ==== rtl/imu_top.sv ====
// integer multiply unit: operand select, multiply and result steering
`timescale 1ns/1ps
`include "imu_defines.svh"
// Overview of operation
// - pair forms write the full product, high half to destination plus one, low half to destination.
// - accumulator forms write base times source into the chosen accumulator, each operand's sign chosen apart.
// - word forms write only the low product to one destination register and nothing else.
// - immediate forms read the five-bit literal as unsigned and send the product to a pair, word or accumulator.
// - the file-register form multiplies the memory word by the default working register into registers three and two.
// - every form but a peripheral register access finishes in one cycle, and no form ever touches the status flags.
// - an access to a special function register outside the core costs one more cycle.
// - accumulator forms exist only when the DSP feature is built in.
module imu_top #(
   parameter bit HAS_DSP = 1'b1
) (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       issue,
   input  wire imu_pkg::imu_dst_t          dst_kind,
   input  wire logic                       base_signed,
   input  wire logic                       src_signed,
   input  wire logic                       use_imm,
   input  wire logic [`IMU_DATA_W-1:0]     base_operand_reg,
   input  wire logic [`IMU_DATA_W-1:0]     source_operand_reg,
   input  wire logic [`IMU_IMM_W-1:0]      five_bit_immediate,
   input  wire logic [`IMU_DATA_W-1:0]     file_word,
   input  wire logic [`IMU_DATA_W-1:0]     default_working_reg,
   input  wire logic                       file_is_periph_sfr,
   input  wire logic [`IMU_ADDR_W-1:0]     dst_index,
   input  wire logic                       acc_sel,
   output logic                            busy,
   output logic                            done,
   output logic                            wr_lo_en,
   output logic [`IMU_ADDR_W-1:0]          wr_lo_addr,
   output logic [`IMU_DATA_W-1:0]          wr_lo_data,
   output logic                            wr_hi_en,
   output logic [`IMU_ADDR_W-1:0]          wr_hi_addr,
   output logic [`IMU_DATA_W-1:0]          wr_hi_data,
   output logic                            acc_a_wr,
   output logic                            acc_b_wr,
   output logic [`IMU_ACC_W-1:0]           acc_data,
   output logic                            illegal_op,
   output logic                            flags_wr
);
   import imu_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      imu_state_t                 st;
      logic                       busy;
      logic                       done;
      logic                       wr_lo_en;
      logic [`IMU_ADDR_W-1:0]     wr_lo_addr;
      logic [`IMU_DATA_W-1:0]     wr_lo_data;
      logic                       wr_hi_en;
      logic [`IMU_ADDR_W-1:0]     wr_hi_addr;
      logic [`IMU_DATA_W-1:0]     wr_hi_data;
      logic                       acc_a_wr;
      logic                       acc_b_wr;
      logic [`IMU_ACC_W-1:0]      acc_data;
      logic                       illegal;
      logic [2*`IMU_DATA_W-1:0]   held_prod;
      logic                       held_sgn;
      logic                       flags_wr;
   } imu_state_s_t;

   imu_state_s_t                  s_r;
   imu_state_s_t                  s_nxt;
   logic [`IMU_DATA_W-1:0]        opa;
   logic [`IMU_DATA_W-1:0]        opb;
   logic                          opa_sgn;
   logic                          opb_sgn;
   logic [2*`IMU_DATA_W-1:0]      prod;
   logic                          prod_sgn;

   // ****************************************
   // operand select
   // ****************************************
   always_comb begin
      if (dst_kind == IMU_DST_FILE) begin
         opa     = file_word;
         opb     = default_working_reg;
         opa_sgn = 1'b0;
         opb_sgn = 1'b0;
      end else begin
         opa     = base_operand_reg;
         opa_sgn = base_signed;
         // the literal is never sign extended
         opb     = use_imm ? {{(`IMU_DATA_W-`IMU_IMM_W){1'b0}}, five_bit_immediate}
                           : source_operand_reg;
         opb_sgn = use_imm ? 1'b0 : src_signed;
      end
   end

   imu_mult_core u_core (
      .opa            (opa),
      .opa_signed     (opa_sgn),
      .opb            (opb),
      .opb_signed     (opb_sgn),
      .product        (prod),
      .product_signed (prod_sgn)
   );

   function automatic logic [`IMU_ACC_W-1:0] acc_ext(input logic [2*`IMU_DATA_W-1:0] p,
                                                     input logic sg);
      acc_ext = {{(`IMU_ACC_W-2*`IMU_DATA_W){sg & p[2*`IMU_DATA_W-1]}}, p};
   endfunction

   // the stalled form is always the file-register form
   function automatic imu_dst_t dst_kind_q(input imu_state_t st, input imu_dst_t kind);
      dst_kind_q = (st == IMU_ST_STALL) ? IMU_DST_FILE : kind;
   endfunction

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [2*`IMU_DATA_W-1:0] p;
      logic                     sg;
      logic                     fire;
      p     = prod;
      sg    = prod_sgn;
      fire  = 1'b0;
      s_nxt = s_r;
      s_nxt.done     = 1'b0;
      s_nxt.wr_lo_en = 1'b0;
      s_nxt.wr_hi_en = 1'b0;
      s_nxt.acc_a_wr = 1'b0;
      s_nxt.acc_b_wr = 1'b0;
      s_nxt.illegal  = 1'b0;
      s_nxt.flags_wr = 1'b0;
      case (s_r.st)
         IMU_ST_IDLE: begin
            if (issue) begin
               // peripheral register reads cost one more cycle
               if (dst_kind == IMU_DST_FILE && file_is_periph_sfr) begin
                  s_nxt.st        = IMU_ST_STALL;
                  s_nxt.busy      = 1'b1;
                  s_nxt.held_prod = prod;
                  s_nxt.held_sgn  = prod_sgn;
               end else begin
                  fire = 1'b1;
               end
            end
         end
         IMU_ST_STALL: begin
            p          = s_r.held_prod;
            sg         = s_r.held_sgn;
            fire       = 1'b1;
            s_nxt.st   = IMU_ST_IDLE;
            s_nxt.busy = 1'b0;
         end
         default: begin
            s_nxt.st   = IMU_ST_IDLE;
            s_nxt.busy = 1'b0;
         end
      endcase
      if (fire) begin
         s_nxt.done = 1'b1;
         case (dst_kind_q(s_r.st, dst_kind))
            IMU_DST_PAIR: begin
               s_nxt.wr_lo_en   = 1'b1;
               s_nxt.wr_lo_addr = dst_index;
               s_nxt.wr_lo_data = p[`IMU_DATA_W-1:0];
               s_nxt.wr_hi_en   = 1'b1;
               s_nxt.wr_hi_addr = 4'(dst_index + 4'h1);
               s_nxt.wr_hi_data = p[2*`IMU_DATA_W-1:`IMU_DATA_W];
            end
            IMU_DST_WORD: begin
               s_nxt.wr_lo_en   = 1'b1;
               s_nxt.wr_lo_addr = dst_index;
               s_nxt.wr_lo_data = p[`IMU_DATA_W-1:0];
            end
            IMU_DST_ACC: begin
               if (HAS_DSP) begin
                  s_nxt.acc_a_wr = ~acc_sel;
                  s_nxt.acc_b_wr = acc_sel;
                  s_nxt.acc_data = acc_ext(p, sg);
               end else begin
                  s_nxt.illegal  = 1'b1;
               end
            end
            default: begin
               s_nxt.wr_lo_en   = 1'b1;
               s_nxt.wr_lo_addr = `IMU_LOW_REG;
               s_nxt.wr_lo_data = p[`IMU_DATA_W-1:0];
               s_nxt.wr_hi_en   = 1'b1;
               s_nxt.wr_hi_addr = `IMU_HIGH_REG;
               s_nxt.wr_hi_data = p[2*`IMU_DATA_W-1:`IMU_DATA_W];
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy       = s_r.busy;
   assign done       = s_r.done;
   assign wr_lo_en   = s_r.wr_lo_en;
   assign wr_lo_addr = s_r.wr_lo_addr;
   assign wr_lo_data = s_r.wr_lo_data;
   assign wr_hi_en   = s_r.wr_hi_en;
   assign wr_hi_addr = s_r.wr_hi_addr;
   assign wr_hi_data = s_r.wr_hi_data;
   assign acc_a_wr   = s_r.acc_a_wr;
   assign acc_b_wr   = s_r.acc_b_wr;
   assign acc_data   = s_r.acc_data;
   assign illegal_op = s_r.illegal;
   // the multiplier never writes status flags
   assign flags_wr   = s_r.flags_wr;

   // ****************************************
   // checks
   // ****************************************
   chk_word_single_write: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && dst_kind == IMU_DST_WORD) |=> (wr_lo_en && !wr_hi_en))
      else $error("word form wrote a second register");
   chk_pair_high_addr: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && dst_kind == IMU_DST_PAIR)
      |=> (wr_hi_en && wr_hi_addr == $past(dst_index) + 4'h1))
      else $error("pair form high half address wrong");
   chk_pair_product: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && dst_kind == IMU_DST_PAIR && !use_imm && !base_signed && !src_signed)
      |=> ({wr_hi_data, wr_lo_data} == $past(base_operand_reg) * $past(source_operand_reg)))
      else $error("unsigned pair product wrong");
   chk_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && !(dst_kind == IMU_DST_FILE && file_is_periph_sfr)) |=> done)
      else $error("multiply took more than one cycle");
   chk_sfr_stall: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && dst_kind == IMU_DST_FILE && file_is_periph_sfr)
      |=> (busy && !done) ##1 (done && wr_hi_addr == `IMU_HIGH_REG))
      else $error("peripheral access did not add one cycle");
   chk_file_dest: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && dst_kind == IMU_DST_FILE && !file_is_periph_sfr)
      |=> (wr_lo_addr == `IMU_LOW_REG && wr_hi_addr == `IMU_HIGH_REG && wr_hi_en))
      else $error("file form wrote wrong registers");
   chk_acc_gate: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && dst_kind == IMU_DST_ACC)
      |=> (HAS_DSP ? (acc_a_wr ^ acc_b_wr) : (illegal_op && !acc_a_wr && !acc_b_wr)))
      else $error("accumulator form gating wrong");
   chk_acc_extend: assert property (@(posedge clk) disable iff (sys_rst)
      (acc_a_wr || acc_b_wr) |-> (acc_data[`IMU_ACC_W-1:2*`IMU_DATA_W] == '0
                                  || (acc_data[`IMU_ACC_W-1:2*`IMU_DATA_W] == '1
                                      && acc_data[2*`IMU_DATA_W-1])))
      else $error("accumulator extension wrong");
   chk_imm_unsigned: assert property (@(posedge clk) disable iff (sys_rst)
      (issue && !busy && use_imm && dst_kind == IMU_DST_WORD && !base_signed)
      |=> (wr_lo_data == 16'(32'($past(base_operand_reg)) * 32'($past(five_bit_immediate)))))
      else $error("immediate not taken unsigned");
endmodule

// ==== inc/imu_defines.svh ====
// constants for the integer multiply unit
`ifndef IMU_DEFINES_SVH
`define IMU_DEFINES_SVH
`define IMU_DATA_W      16
`define IMU_ADDR_W      4
`define IMU_ACC_W       40
`define IMU_IMM_W       5
`define IMU_LOW_REG     4'h2
`define IMU_HIGH_REG    4'h3
`define IMU_EXTRA_CYC   1
`define IMU_RST_WORD    16'h0000
`endif

// ==== inc/imu_pkg.sv ====
// types shared by the integer multiply unit
package imu_pkg;
   // where the product goes
   typedef enum logic [1:0] {
      IMU_DST_PAIR,
      IMU_DST_WORD,
      IMU_DST_ACC,
      IMU_DST_FILE
   } imu_dst_t;
   typedef enum logic [1:0] {
      IMU_ST_IDLE,
      IMU_ST_STALL
   } imu_state_t;
endpackage

// ==== rtl/imu_mult_core.sv ====
// 17x17 signed multiplier core shared by every multiply form
`timescale 1ns/1ps
`include "imu_defines.svh"
module imu_mult_core (
   input  wire logic [`IMU_DATA_W-1:0]   opa,
   input  wire logic                     opa_signed,
   input  wire logic [`IMU_DATA_W-1:0]   opb,
   input  wire logic                     opb_signed,
   output logic      [2*`IMU_DATA_W-1:0] product,
   output logic                          product_signed
);
   logic signed [`IMU_DATA_W:0]     ext_a;
   logic signed [`IMU_DATA_W:0]     ext_b;
   logic signed [2*`IMU_DATA_W+1:0] full;
   // one extra bit per operand lets one signed array serve all four sign mixes
   assign ext_a          = {opa_signed & opa[`IMU_DATA_W-1], opa};
   assign ext_b          = {opb_signed & opb[`IMU_DATA_W-1], opb};
   assign full           = ext_a * ext_b;
   assign product        = full[2*`IMU_DATA_W-1:0];
   assign product_signed = opa_signed | opb_signed;
endmodule

// ==== bench/imu_regfile_model.sv ====
// working register file and accumulators that take the multiply unit's writes
`timescale 1ns/1ps
`include "imu_defines.svh"
module imu_regfile_model (
   input wire logic                   clk,
   input wire logic                   sys_rst,
   input wire logic                   wr_lo_en,
   input wire logic [`IMU_ADDR_W-1:0] wr_lo_addr,
   input wire logic [`IMU_DATA_W-1:0] wr_lo_data,
   input wire logic                   wr_hi_en,
   input wire logic [`IMU_ADDR_W-1:0] wr_hi_addr,
   input wire logic [`IMU_DATA_W-1:0] wr_hi_data,
   input wire logic                   acc_a_wr,
   input wire logic                   acc_b_wr,
   input wire logic [`IMU_ACC_W-1:0]  acc_data
);
   logic [`IMU_DATA_W-1:0] rf [16];
   logic [`IMU_ACC_W-1:0]  acc_a;
   logic [`IMU_ACC_W-1:0]  acc_b;
   // each register starts at index times 1111 so a stray write shows up
   always @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 16; i++)
            rf[i] <= 16'(i) * 16'h1111;
      end else begin
         if (wr_lo_en)
            rf[wr_lo_addr] <= wr_lo_data;
         if (wr_hi_en)
            rf[wr_hi_addr] <= wr_hi_data;
         if (acc_a_wr)
            acc_a <= acc_data;
         if (acc_b_wr)
            acc_b <= acc_data;
      end
   end
endmodule

// ==== bench/integer_multiply_unit_bench.sv ====
// self-checking bench for the integer multiply unit
`timescale 1ns/1ps
`include "imu_defines.svh"
module integer_multiply_unit_bench;
   import imu_pkg::*;
   logic clk = 1'b0, sys_rst = 1'b1, issue = 1'b0, use_imm = 1'b0, acc_sel = 1'b0;
   logic base_signed = 1'b0, src_signed = 1'b0, file_is_periph_sfr = 1'b0;
   imu_dst_t dst_kind = IMU_DST_PAIR;
   logic [15:0] base_operand_reg = '0, source_operand_reg = '0;
   logic [15:0] file_word = '0, default_working_reg = '0;
   logic [4:0] five_bit_immediate = '0;
   logic [3:0] dst_index = '0;
   logic busy, done, wr_lo_en, wr_hi_en, acc_a_wr, acc_b_wr, illegal_op, flags_wr;
   logic [3:0] wr_lo_addr, wr_hi_addr;
   logic [15:0] wr_lo_data, wr_hi_data;
   logic [39:0] acc_data;
   logic nd_done, nd_illegal, nd_acc_a_wr, nd_acc_b_wr;
   int err_total = 0;
   int n_tests = 0;

   always #5 clk = ~clk;

   imu_top #(.HAS_DSP(1'b1)) uut (.clk, .sys_rst, .issue, .dst_kind, .base_signed,
      .src_signed, .use_imm, .base_operand_reg, .source_operand_reg, .five_bit_immediate,
      .file_word, .default_working_reg, .file_is_periph_sfr, .dst_index, .acc_sel, .busy,
      .done, .wr_lo_en, .wr_lo_addr, .wr_lo_data, .wr_hi_en, .wr_hi_addr, .wr_hi_data,
      .acc_a_wr, .acc_b_wr, .acc_data, .illegal_op, .flags_wr);

   imu_regfile_model u_rf (.clk, .sys_rst, .wr_lo_en, .wr_lo_addr, .wr_lo_data,
      .wr_hi_en, .wr_hi_addr, .wr_hi_data, .acc_a_wr, .acc_b_wr, .acc_data);

   // a build without the DSP feature sees the same stimulus
   imu_top #(.HAS_DSP(1'b0)) uut_nodsp (.clk, .sys_rst, .issue, .dst_kind, .base_signed,
      .src_signed, .use_imm, .base_operand_reg, .source_operand_reg, .five_bit_immediate,
      .file_word, .default_working_reg, .file_is_periph_sfr, .dst_index, .acc_sel,
      .busy(), .done(nd_done), .wr_lo_en(), .wr_lo_addr(), .wr_lo_data(), .wr_hi_en(),
      .wr_hi_addr(), .wr_hi_data(), .acc_a_wr(nd_acc_a_wr), .acc_b_wr(nd_acc_b_wr),
      .acc_data(), .illegal_op(nd_illegal), .flags_wr());

   // ************************************************************
   // shared helpers
   // ************************************************************
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // sign or zero extend each operand to 40 bits so one product fits every form
   function automatic logic [39:0] prod(input logic [15:0] a, input logic sa,
                                        input logic [15:0] b, input logic sb);
      logic [39:0] x;
      logic [39:0] y;
      x = {{24{sa & a[15]}}, a};
      y = {{24{sb & b[15]}}, b};
      return x * y;
   endfunction

   // poke keeps issue up through the stall cycle, where it must be ignored
   task automatic op(input imu_dst_t k, input logic sa, input logic sb, input logic im,
                     input logic [15:0] a, input logic [15:0] b, input logic [4:0] lit,
                     input logic special_function_register, input logic poke, input logic [3:0] d,
                     input logic ac);
      logic [39:0] p;
      logic [3:0] fa;
      logic b1;
      int n;
      @(posedge clk);
      issue <= 1'b1;
      dst_kind <= k;
      base_signed <= sa;
      src_signed <= sb;
      use_imm <= im;
      base_operand_reg <= a;
      source_operand_reg <= b;
      file_word <= a;
      default_working_reg <= b;
      five_bit_immediate <= lit;
      file_is_periph_sfr <= special_function_register;
      dst_index <= d;
      acc_sel <= ac;
      if (k == IMU_DST_FILE) p = prod(a, 1'b0, b, 1'b0);
      else if (im) p = prod(a, sa, {11'h000, lit}, 1'b0);
      else p = prod(a, sa, b, sb);
      fa = (k == IMU_DST_FILE) ? 4'h2 : d;
      @(posedge clk);
      issue <= poke;
      #1;
      b1 = busy;
      n = 1;
      while (done !== 1'b1 && n < 4) begin
         @(posedge clk);
         issue <= 1'b0;
         #1;
         n++;
      end
      if (done !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED done expected 1 seen %b", done);
         end_of_test();
      end
      check("latency", 40'(n), (k == IMU_DST_FILE && special_function_register) ? 40'd2 : 40'd1);
      check("busy", 40'(b1), 40'(k == IMU_DST_FILE && special_function_register));
      check("flags_wr", 40'(flags_wr), 40'd0);
      check("enables", {wr_hi_en, wr_lo_en, acc_b_wr, acc_a_wr, illegal_op},
            {k != IMU_DST_ACC && k != IMU_DST_WORD, k != IMU_DST_ACC,
             k == IMU_DST_ACC && ac, k == IMU_DST_ACC && !ac, 1'b0});
      if (k == IMU_DST_ACC) check("acc_data", acc_data, p);
      else if (k == IMU_DST_WORD) check("word", {wr_lo_addr, wr_lo_data}, {d, p[15:0]});
      else check("pair", {wr_hi_addr, wr_lo_addr, wr_hi_data, wr_lo_data},
                 {fa + 4'h1, fa, p[31:0]});
      check("no dsp gate", {nd_done, nd_illegal, nd_acc_b_wr, nd_acc_a_wr},
            {1'b1, k == IMU_DST_ACC, 2'b00});
      @(posedge clk);
      #1;
      check("done pulse", 40'(done), 40'd0);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_pair();
      for (int i = 0; i < 4; i++) begin
         op(IMU_DST_PAIR, i[1], i[0], 1'b0, 16'h8000, 16'hffff, 5'h00, 1'b0, 1'b0, 4'h4, 1'b0);
         op(IMU_DST_PAIR, i[1], i[0], 1'b0, 16'h1234, 16'hfedc, 5'h00, 1'b0, 1'b0, 4'h4, 1'b0);
      end
      $display("pair test done");
   endtask

   task automatic t_word();
      for (int i = 0; i < 4; i++)
         op(IMU_DST_WORD, i[1], i[0], 1'b0, 16'h8001, 16'hff7f, 5'h00, 1'b0, 1'b0, 4'h8, 1'b0);
      check("neighbour", 40'(u_rf.rf[9]), 40'h99_9999 & 40'hffff);
      check("word reg", 40'(u_rf.rf[8]), 40'h7f7f);
      $display("word test done");
   endtask

   task automatic t_acc();
      for (int i = 0; i < 4; i++)
         op(IMU_DST_ACC, i[1], i[0], 1'b0, 16'h8000, 16'hffff, 5'h00, 1'b0, 1'b0, 4'h0, i[0]);
      check("acc a", u_rf.acc_a, prod(16'h8000, 1'b1, 16'hffff, 1'b0));
      check("acc b", u_rf.acc_b, prod(16'h8000, 1'b1, 16'hffff, 1'b1));
      $display("accumulator test done");
   endtask

   task automatic t_imm();
      for (int i = 0; i < 6; i++)
         op(imu_dst_t'(2'(i / 2)), i[0], 1'b1, 1'b1, 16'hfff3, 16'h5a5a, 5'h1f, 1'b0, 1'b0,
            4'h6, 1'b1);
      $display("immediate test done");
   endtask

   task automatic t_file();
      op(IMU_DST_FILE, 1'b1, 1'b1, 1'b0, 16'hffff, 16'h8000, 5'h00, 1'b0, 1'b0, 4'h8, 1'b0);
      op(IMU_DST_FILE, 1'b1, 1'b1, 1'b0, 16'hfffe, 16'hffff, 5'h00, 1'b1, 1'b1, 4'h8, 1'b0);
      $display("file register test done");
   endtask

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
      check("reset outputs", {busy, done, wr_lo_en, wr_hi_en, acc_a_wr, acc_b_wr, illegal_op},
            40'd0);
      t_pair();
      t_word();
      t_acc();
      t_imm();
      t_file();
      end_of_test();
   end
endmodule
